// ### core/dadc_top.sv
// Digital control and output stage of a dual 10-bit converter.
// Assumes the converter cores deliver one aligned I/Q word per clock,
// synchronous to clk_i, and software drives the controls over Avalon-MM.
`timescale 1ns/100ps
`include "dadc_map.svh"

////////////////////////////////////////////////////////////////////////
// Result FIFO between correction and the output buses.
// Assumes one clock and an active-low asynchronous reset.
module dadc_fifo #(
	parameter int WIDTH = 20,
	parameter int DEPTH = 8,
	parameter int LW = $clog2(DEPTH + 1)
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Filling side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Draining side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o,
	output logic [LW-1:0] level_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [LW-1:0] cnt;
	} dadc_fifo_st_t;
	dadc_fifo_st_t st_r;
	dadc_fifo_st_t st_nxt;
	logic push;
	logic pop;
	assign in_ready_o = (st_r.cnt != LW'(DEPTH));
	assign out_valid_o = (st_r.cnt != '0);
	assign out_data_o = st_r.mem[st_r.rp];
	assign level_o = st_r.cnt;
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;
	always_comb begin
		st_nxt = st_r;
		if (push) begin
			st_nxt.mem[st_r.wp] = in_data_i;
			st_nxt.wp = (st_r.wp == AW'(DEPTH - 1)) ? '0 : AW'(st_r.wp + 1'b1);
		end
		if (pop) begin
			st_nxt.rp = (st_r.rp == AW'(DEPTH - 1)) ? '0 : AW'(st_r.rp + 1'b1);
		end
		st_nxt.cnt = LW'(st_r.cnt + LW'(push) - LW'(pop));
	end
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule : dadc_fifo

////////////////////////////////////////////////////////////////////////
module dadc_top #(
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Avalon-MM register slave
	input wire dadc_pkg::dadc_avs_req_t avs_req_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Raw words from the converter cores
	input wire dadc_pkg::dadc_pair_t raw_i,
	input wire logic raw_valid_i,
	output logic raw_ready_o,
	// Output buses to capture logic
	output dadc_pkg::dadc_pair_t bus_o,
	output logic word_valid_o,
	output logic word_is_q_o,
	input wire logic bus_ready_i,
	// Analog control levels
	output logic range_select_o,
	output logic light_sleep_o,
	output logic deep_sleep_o,
	output logic trim_busy_o
);
	import dadc_pkg::*;

	////////////////////////////////////////////////////////////////////
	localparam int LW = $clog2(DEPTH + 1);
	localparam int SHIFT = $clog2(`DADC_TRIM_SAMPLES);

	typedef struct packed {
		logic [5:0] ctrl;
		logic trim_go_d;
		dadc_pwr_t pwr;
		dadc_trim_t trim;
		logic [5:0] trim_cnt;
		logic signed [15:0] acc_i;
		logic signed [15:0] acc_q;
		logic signed [10:0] ofs_i;
		logic signed [10:0] ofs_q;
		logic trim_done;
		logic waitreq;
		logic [31:0] rdata;
		dadc_pair_t bus;
		logic valid;
		logic is_q;
		logic pend_q;
		logic [9:0] held_q;
		logic ready;
		logic light;
		logic deep;
		logic busy;
	} dadc_state_t;

	dadc_state_t st_r;
	dadc_state_t st_nxt;
	dadc_pair_t fifo_in;
	dadc_pair_t fifo_out;
	logic fifo_in_valid;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [LW-1:0] fifo_level;
	logic trim_rise;
	logic run;
	logic [LW:0] level_next;

	// Offset removal with clamping, so the usable code range shrinks
	function automatic logic [9:0] dadc_fix(input logic [9:0] raw,
		input logic signed [10:0] ofs, input logic twos);
		logic signed [11:0] v;
		logic [9:0] c;
		v = $signed({2'b00, raw}) - `DADC_MID - $signed({ofs[10], ofs});
		if (v > $signed(12'h1FF)) begin
			v = $signed(12'h1FF);
		end else if (v < $signed(12'hE00)) begin
			v = $signed(12'hE00);
		end
		c = v[9:0];
		return twos ? c : {~c[9], c[8:0]};
	endfunction : dadc_fix

	////////////////////////////////////////////////////////////////////
	// one word, both channels
	assign fifo_in.i = dadc_fix(raw_i.i, st_r.ofs_i, st_r.ctrl[`DADC_C_FMT]);
	assign fifo_in.q = dadc_fix(raw_i.q, st_r.ofs_q, st_r.ctrl[`DADC_C_FMT]);
	assign fifo_in_valid = raw_valid_i && st_r.ready;
	assign run = (st_r.pwr == PWR_RUN);
	assign fifo_out_ready = run && !st_r.pend_q;
	assign trim_rise = st_r.ctrl[`DADC_C_TRIM] && !st_r.trim_go_d;

	dadc_fifo #(
		.WIDTH($bits(dadc_pair_t)),
		.DEPTH(DEPTH),
		.LW(LW)
	) u_fifo (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.in_valid_i(fifo_in_valid),
		.in_ready_o(),
		.in_data_i(fifo_in),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(fifo_out_ready),
		.out_data_o(fifo_out),
		.level_o(fifo_level)
	);

	////////////////////////////////////////////////////////////////////
	always_comb begin
		st_nxt = st_r;
		level_next = (LW + 1)'({1'b0, fifo_level} + (LW + 1)'(fifo_in_valid)
			- (LW + 1)'(fifo_out_valid && fifo_out_ready));
		// Register slave: one wait cycle, then the answer
		if (st_r.waitreq) begin
			if (avs_req_i.read || avs_req_i.write) begin
				st_nxt.waitreq = 1'b0;
				case (avs_req_i.address)
					`DADC_CTRL_OFS: st_nxt.rdata = {26'h0000000, st_r.ctrl};
					`DADC_STAT_OFS: begin
						st_nxt.rdata = 32'h00000000;
						st_nxt.rdata[`DADC_S_BUSY] = (st_r.trim == TRIM_RUN);
						st_nxt.rdata[`DADC_S_DONE] = st_r.trim_done;
						st_nxt.rdata[`DADC_S_PWR +: 2] = st_r.pwr;
						st_nxt.rdata[`DADC_S_LVL +: LW] = fifo_level;
					end
					`DADC_OFST_OFS: begin
						st_nxt.rdata = 32'h00000000;
						st_nxt.rdata[10:0] = st_r.ofs_i;
						st_nxt.rdata[`DADC_OFS_Q +: 11] = st_r.ofs_q;
					end
					default: st_nxt.rdata = 32'h00000000;
				endcase
			end
		end else begin
			st_nxt.waitreq = 1'b1;
			if (avs_req_i.write && avs_req_i.address == `DADC_CTRL_OFS) begin
				st_nxt.ctrl = avs_req_i.writedata[5:0];
			end
		end
		if (st_r.ctrl[`DADC_C_DEEP]) begin
			st_nxt.pwr = PWR_DEEP;
		end else if (st_r.ctrl[`DADC_C_LIGHT]) begin
			st_nxt.pwr = PWR_LIGHT;
		end else begin
			st_nxt.pwr = PWR_RUN;
		end
		st_nxt.ready = (st_nxt.pwr == PWR_RUN) && (level_next < (LW + 1)'(DEPTH));
		// Offset trim sequence
		st_nxt.trim_go_d = st_r.ctrl[`DADC_C_TRIM];
		case (st_r.trim)
			TRIM_IDLE: begin
				if (trim_rise) begin
					st_nxt.trim = TRIM_RUN;
					st_nxt.trim_cnt = 6'h00;
					st_nxt.acc_i = 16'sh0000;
					st_nxt.acc_q = 16'sh0000;
					st_nxt.trim_done = 1'b0;
				end
			end
			TRIM_RUN: begin
				st_nxt.trim_cnt = st_r.trim_cnt + 6'h01;
				if (st_r.trim_cnt < 6'(`DADC_TRIM_SAMPLES)) begin
					st_nxt.acc_i = st_r.acc_i + 16'(signed'({2'b00, raw_i.i}) - `DADC_MID);
					st_nxt.acc_q = st_r.acc_q + 16'(signed'({2'b00, raw_i.q}) - `DADC_MID);
				end
				if (st_r.trim_cnt == 6'(`DADC_TRIM_CYCLES - 1)) begin
					st_nxt.trim = TRIM_IDLE;
					st_nxt.ofs_i = 11'(st_r.acc_i >>> SHIFT);
					st_nxt.ofs_q = 11'(st_r.acc_q >>> SHIFT);
					st_nxt.trim_done = 1'b1;
				end
			end
			default: st_nxt.trim = TRIM_IDLE;
		endcase
		st_nxt.valid = 1'b0;
		if (run) begin
			if (st_r.pend_q) begin
				// Q word follows its I word
				st_nxt.bus.i = st_r.held_q;
				st_nxt.bus.q = 10'h000;
				st_nxt.is_q = 1'b1;
				st_nxt.valid = 1'b1;
				st_nxt.pend_q = 1'b0;
			end else if (fifo_out_valid) begin
				st_nxt.valid = 1'b1;
				st_nxt.is_q = 1'b0;
				if (st_r.ctrl[`DADC_C_LAYOUT]) begin
					st_nxt.bus = fifo_out;
				end else begin
					st_nxt.bus.i = fifo_out.i;
					st_nxt.bus.q = 10'h000;
					st_nxt.held_q = fifo_out.q;
					st_nxt.pend_q = 1'b1;
				end
			end
		end
		// Q lines low in mux mode while running
		if (!st_r.ctrl[`DADC_C_LAYOUT] && run) begin
			st_nxt.bus.q = 10'h000;
		end
		// Level pins kept as flops so they never glitch on decode
		st_nxt.light = (st_nxt.pwr == PWR_LIGHT);
		st_nxt.deep = (st_nxt.pwr == PWR_DEEP);
		st_nxt.busy = (st_nxt.trim == TRIM_RUN);
	end

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_r <= '0;
			st_r.ctrl <= `DADC_CTRL_RST;
			st_r.waitreq <= 1'b1;
			st_r.pwr <= PWR_RUN;
			st_r.trim <= TRIM_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs always driven from flops
	assign avs_readdata_o = st_r.rdata;
	assign avs_waitrequest_o = st_r.waitreq;
	assign raw_ready_o = st_r.ready;
	assign bus_o = st_r.bus;
	assign word_valid_o = st_r.valid;
	assign word_is_q_o = st_r.is_q;
	// range select to the front end
	assign range_select_o = st_r.ctrl[`DADC_C_RANGE];
	assign light_sleep_o = st_r.light;
	assign deep_sleep_o = st_r.deep;
	assign trim_busy_o = st_r.busy;

	// Bus ready is unused: capture logic must take words as they come
	logic unused_ready;
	assign unused_ready = bus_ready_i;

	////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!reset_n_i);

	par_bus_a: assert property (
		(run && !st_r.pend_q && fifo_out_valid && st_r.ctrl[`DADC_C_LAYOUT])
		|=> (bus_o == $past(fifo_out)) && word_valid_o && !word_is_q_o)
		else $error("parallel word not on its buses");

	mux_q_low_a: assert property (
		(run && !st_r.ctrl[`DADC_C_LAYOUT]) |=> (bus_o.q == 10'h000))
		else $error("Q bus not low in multiplexed mode");

	trim_start_a: assert property (
		(st_r.trim == TRIM_IDLE && trim_rise) |=> trim_busy_o && st_r.trim_cnt == 6'h00)
		else $error("trim did not start on rising trigger");

	trim_len_a: assert property (
		$rose(trim_busy_o) |-> ##33 trim_busy_o ##1 (!trim_busy_o && st_r.trim_done))
		else $error("trim sequence length wrong");

	ofs_take_a: assert property (
		(trim_busy_o && st_r.trim_cnt == 6'(`DADC_TRIM_CYCLES - 1))
		|=> st_r.ofs_i == 11'($past(st_r.acc_i) >>> SHIFT)
		&& st_r.ofs_q == 11'($past(st_r.acc_q) >>> SHIFT))
		else $error("averaged offset not taken");

	fmt_ob_zero_a: assert property (
		(fifo_in_valid && raw_i.i == 10'h200 && st_r.ofs_i == 11'sh000
		&& !st_r.ctrl[`DADC_C_FMT]) |-> fifo_in.i == 10'h200)
		else $error("offset binary zero code wrong");

	fmt_tc_full_a: assert property (
		(fifo_in_valid && raw_i.i == 10'h3FF && st_r.ofs_i == 11'sh000
		&& st_r.ctrl[`DADC_C_FMT]) |-> fifo_in.i == 10'h1FF)
		else $error("two's complement full scale wrong");

	sleep_stall_a: assert property (
		(st_r.pwr != PWR_RUN) |-> !raw_ready_o ##1 !word_valid_o)
		else $error("conversion while asleep");

	sleep_hold_a: assert property (
		(st_r.pwr == PWR_LIGHT) |=> $stable(bus_o) && $stable(word_is_q_o))
		else $error("outputs moved in light sleep");

	deep_hold_a: assert property (
		(st_r.pwr == PWR_DEEP) |=> $stable(bus_o))
		else $error("outputs moved in deep sleep");

	deep_wins_a: assert property (
		st_r.ctrl[`DADC_C_DEEP] |=> deep_sleep_o && !light_sleep_o)
		else $error("deep sleep did not win");

	mux_order_a: assert property (
		(run && !st_r.pend_q && fifo_out_valid && !st_r.ctrl[`DADC_C_LAYOUT]
		&& !st_r.ctrl[`DADC_C_LIGHT] && !st_r.ctrl[`DADC_C_DEEP])
		|=> (word_valid_o && !word_is_q_o) ##1 (word_valid_o && word_is_q_o))
		else $error("multiplexed order broken");

	trim_ignore_a: assert property (
		(trim_busy_o && st_r.trim_cnt < 6'(`DADC_TRIM_CYCLES - 1))
		|=> trim_busy_o && st_r.trim_cnt == $past(st_r.trim_cnt) + 6'h01)
		else $error("trim restarted while running");

	no_overflow_a: assert property (
		fifo_in_valid |-> fifo_level < LW'(DEPTH))
		else $error("push into full FIFO");

	bus_wait_a: assert property (
		(avs_waitrequest_o && (avs_req_i.read || avs_req_i.write)) |=> !avs_waitrequest_o)
		else $error("register access not answered");

	trim_done_c: cover property ($fell(trim_busy_o));
	mux_pair_c: cover property (word_valid_o && !word_is_q_o ##1 word_is_q_o);
	light_hold_c: cover property (light_sleep_o [*4]);
	fifo_full_c: cover property (fifo_level == LW'(DEPTH));
endmodule : dadc_top

// ### core/dadc_map.svh
// Offsets, field positions, reset values and timing counts of the
// dual converter output control. Included by the core file only.
//
// What this block does
// - Layout select high: each channel own bus
// - Layout select low: interleave on I, Q low
// - Trim trigger rise starts trim per channel
// - Trim lasts 34 cycles, averages 32 conversions
// - Subtract averaged offset from later results
// - Format select: low offset binary, high two's
// - Runs only with both sleep requests low
// - Light sleep holds last result on outputs
// - Deep sleep deepest, wins over light sleep
// - Deep sleep holds last result on outputs
// - Data outputs always driven, never floating
// - Offset binary: 3FF, 200, 000 codes
// - Two's complement: 1FF, 000, 200 codes
// - Range select high doubles full scale
// - Both channels sampled at the same instant
`ifndef DADC_MAP_SVH
`define DADC_MAP_SVH
`define DADC_CTRL_OFS 4'h0
`define DADC_STAT_OFS 4'h4
`define DADC_OFST_OFS 4'h8
`define DADC_C_LAYOUT 0
`define DADC_C_FMT 1
`define DADC_C_RANGE 2
`define DADC_C_LIGHT 3
`define DADC_C_DEEP 4
`define DADC_C_TRIM 5
`define DADC_CTRL_RST 6'h01
`define DADC_S_BUSY 0
`define DADC_S_DONE 1
`define DADC_S_PWR 4
`define DADC_S_LVL 8
`define DADC_OFS_Q 16
`define DADC_MID 12'sh200
`define DADC_TRIM_CYCLES 34
`define DADC_TRIM_SAMPLES 32
`endif

// ### core/dadc_pkg.sv
// Types shared by the converter output control and its bench.
// Assumes 10-bit converter words and a 32-bit register bus.
package dadc_pkg;
	typedef struct packed {
		logic read;
		logic write;
		logic [3:0] address;
		logic [31:0] writedata;
	} dadc_avs_req_t;
	typedef struct packed {
		logic [9:0] i;
		logic [9:0] q;
	} dadc_pair_t;
	typedef enum logic [1:0] {PWR_RUN, PWR_LIGHT, PWR_DEEP} dadc_pwr_t;
	typedef enum logic {TRIM_IDLE, TRIM_RUN} dadc_trim_t;
endpackage : dadc_pkg

// ### core/dadc_fifo.sv
// Result FIFO: the module dadc_fifo sits in dadc_top.sv, beside the
// top that uses it, so that one design file holds all the logic.

// ### test/dadc_capture.sv
// Capture model: logs every word the output stage presents.
// Assumes words are taken as they come, so ready is held high.
`timescale 1ns/100ps
module dadc_capture (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// Output buses of the block
	input wire dadc_pkg::dadc_pair_t bus_i,
	input wire logic word_valid_i,
	input wire logic word_is_q_i,
	output logic bus_ready_o
);
	import dadc_pkg::*;
	dadc_pair_t words[$];
	logic kinds[$];
	// Real capture logic cannot stall the converter
	assign bus_ready_o = 1'b1;
	always @(posedge clk_i) begin
		if (reset_n_i && word_valid_i === 1'b1) begin
			words.push_back(bus_i);
			kinds.push_back(word_is_q_i);
		end
	end
endmodule : dadc_capture

// ### test/tb_dadc_top.sv
// Self-checking bench of the converter output control.
// Assumes the capture model of dadc_capture on the output side.
`timescale 1ns/100ps
module tb_dadc_top;
	import dadc_pkg::*;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	dadc_avs_req_t avs_req_i = '0;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	dadc_pair_t raw_i = '0;
	logic raw_valid_i = 1'b0;
	logic raw_ready_o;
	dadc_pair_t bus_o;
	logic word_valid_o;
	logic word_is_q_o;
	logic bus_ready_i;
	logic range_select_o;
	logic light_sleep_o;
	logic deep_sleep_o;
	logic trim_busy_o;
	int error_cnt = 0;
	int compares = 0;
	int busy_cnt = 0;
	logic [31:0] rd;
	always #25 clk_i = ~clk_i;
	always @(posedge clk_i) if (trim_busy_o === 1'b1) busy_cnt <= busy_cnt + 1;
	dadc_top #(.DEPTH(8)) i_dadc_top (.clk_i(clk_i), .reset_n_i(reset_n_i),
		.avs_req_i(avs_req_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .raw_i(raw_i), .raw_valid_i(raw_valid_i),
		.raw_ready_o(raw_ready_o), .bus_o(bus_o), .word_valid_o(word_valid_o),
		.word_is_q_o(word_is_q_o), .bus_ready_i(bus_ready_i),
		.range_select_o(range_select_o), .light_sleep_o(light_sleep_o),
		.deep_sleep_o(deep_sleep_o), .trim_busy_o(trim_busy_o));
	dadc_capture i_dadc_capture (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus_i(bus_o),
		.word_valid_i(word_valid_o), .word_is_q_i(word_is_q_o), .bus_ready_o(bus_ready_i));
	////////////////////////////////////////
	task automatic test_done();
		$display("Counts: %0d compares, %0d mismatches", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic give_up();
		chk(32'h0, 32'h1);
		test_done();
	endtask : give_up
	// One Avalon access; holds the request until waitrequest is seen low
	task automatic avs(input logic rd_en, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_i);
		avs_req_i <= '{read: rd_en, write: !rd_en, address: a, writedata: d};
		for (n = 0; n < 20; n++) begin
			@(posedge clk_i);
			if (avs_waitrequest_o === 1'b0) break;
		end
		rd = avs_readdata_o;
		avs_req_i <= '0;
		if (n == 20) give_up();
	endtask : avs
	// Waits for the word to be taken, then lets the lines go stale
	task automatic take();
		int n;
		for (n = 0; n < 20; n++) begin
			@(posedge clk_i);
			if (raw_ready_o === 1'b1) break;
		end
		raw_valid_i <= 1'b0;
		raw_i <= ~raw_i;
		if (n == 20) give_up();
		repeat (4) @(posedge clk_i);
	endtask : take
	task automatic send(input logic [9:0] i, input logic [9:0] q);
		@(posedge clk_i);
		raw_i <= {i, q};
		raw_valid_i <= 1'b1;
		take();
	endtask : send
	task automatic word(input logic k, input logic [9:0] i, input logic [9:0] q);
		if (i_dadc_capture.words.size() == 0) give_up();
		chk({i_dadc_capture.kinds.pop_front(), i_dadc_capture.words.pop_front()}, {k, i, q});
	endtask : word
	////////////////////////////////////////
	task automatic t_regs();
		avs(1, 4'h0, 32'h0);
		chk(rd, 32'h1);
		avs(0, 4'hC, 32'hFFFF_FFFF);
		avs(0, 4'h4, 32'hFFFF_FFFF);
		avs(1, 4'hC, 32'h0);
		chk(rd, 32'h0);
		avs(1, 4'h4, 32'h0);
		chk(rd, 32'h0);
		avs(0, 4'h0, 32'h5);
		repeat (2) @(posedge clk_i);
		chk(range_select_o, 32'h1);
		avs(0, 4'h0, 32'h1);
		repeat (2) @(posedge clk_i);
		chk(range_select_o, 32'h0);
		$display("test regs ended");
	endtask : t_regs
	task automatic t_codes();
		logic [9:0] c [3] = '{10'h3FF, 10'h200, 10'h000};
		for (int f = 0; f < 2; f++) begin
			avs(0, 4'h0, 32'(1 + 2 * f));
			for (int k = 0; k < 3; k++) begin
				send(c[k], ~c[k]);
				word(0, c[k] ^ {f[0], 9'h0}, ~c[k] ^ {f[0], 9'h0});
			end
		end
		$display("test codes ended");
	endtask : t_codes
	task automatic t_mux();
		avs(0, 4'h0, 32'h0);
		send(10'h123, 10'h2AB);
		word(0, 10'h123, 10'h000);
		word(1, 10'h2AB, 10'h000);
		avs(0, 4'h0, 32'h1);
		$display("test mux ended");
	endtask : t_mux
	task automatic t_trim();
		int n;
		raw_i <= {10'h204, 10'h1FC};
		busy_cnt = 0;
		avs(0, 4'h0, 32'h21);
		for (n = 0; n < 10 && busy_cnt == 0; n++) @(posedge clk_i);
		if (n == 10) give_up();
		avs(0, 4'h0, 32'h1);
		avs(0, 4'h0, 32'h21);
		for (n = 0; n < 40 && trim_busy_o !== 1'b0; n++) @(posedge clk_i);
		if (n == 40) give_up();
		repeat (35) @(posedge clk_i);
		chk(busy_cnt, 32'd34);
		avs(1, 4'h8, 32'h0);
		chk(rd, 32'h07FC_0004);
		avs(1, 4'h4, 32'h0);
		chk(rd[1:0], 32'h2);
		send(10'h300, 10'h300);
		word(0, 10'h2FC, 10'h304);
		send(10'h002, 10'h3FE);
		word(0, 10'h000, 10'h3FF);
		$display("test trim ended");
	endtask : t_trim
	task automatic t_sleep();
		send(10'h280, 10'h180);
		word(0, 10'h27C, 10'h184);
		avs(0, 4'h0, 32'h9);
		repeat (2) @(posedge clk_i);
		chk({light_sleep_o, raw_ready_o}, 32'h2);
		raw_i <= {10'h3C0, 10'h040};
		raw_valid_i <= 1'b1;
		repeat (10) @(posedge clk_i);
		chk(bus_o, {10'h27C, 10'h184});
		avs(0, 4'h0, 32'h19);
		repeat (2) @(posedge clk_i);
		chk(deep_sleep_o, 32'h1);
		avs(1, 4'h4, 32'h0);
		chk(rd[5:4], 32'h2);
		chk(bus_o, {10'h27C, 10'h184});
		chk(i_dadc_capture.words.size(), 32'h0);
		avs(0, 4'h0, 32'h1);
		take();
		word(0, 10'h3BC, 10'h044);
		$display("test sleep ended");
	endtask : t_sleep
	////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk_i);
		reset_n_i <= 1'b1;
		t_regs();
		t_codes();
		t_mux();
		t_trim();
		t_sleep();
		test_done();
	end
endmodule : tb_dadc_top
